// >>> include/ifr_pkg.sv
// Constants, types and helpers for the input function router
package ifr_pkg;

    localparam int NUM_HW   = 6;
    localparam int NUM_VIRT = 16;
    localparam int NUM_IN   = NUM_HW + NUM_VIRT;
    localparam int CODE_W   = 8;
    localparam int ADDR_W   = 5;
    localparam int DATA_W   = 8;
    localparam int IDX_W    = 5;

    // Register offsets; hardware selects sit at input number minus one, virtual selects run from 0x08
    localparam logic [ADDR_W-1:0] ADDR_SEL_HW_FIRST   = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_SEL_HW_LAST    = 5'h05;
    localparam logic [ADDR_W-1:0] ADDR_SEL_VIRT_FIRST = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_SEL_VIRT_LAST  = 5'h17;
    localparam logic [ADDR_W-1:0] ADDR_VIRT_LO        = 5'h18;
    localparam logic [ADDR_W-1:0] ADDR_VIRT_HI        = 5'h19;
    localparam logic [ADDR_W-1:0] ADDR_RESTART        = 5'h1a;
    localparam logic [ADDR_W-1:0] ADDR_PIN_LEVEL      = 5'h1b;
    localparam logic [ADDR_W-1:0] ADDR_FUNC0          = 5'h1c;
    localparam logic [ADDR_W-1:0] ADDR_FUNC1          = 5'h1d;
    localparam logic [ADDR_W-1:0] ADDR_FUNC2          = 5'h1e;
    localparam logic [IDX_W-1:0]  VIRT_IDX_GAP        = 5'h02;
    localparam logic [IDX_W-1:0]  LAST_IDX            = 5'h15;

    // Reset values
    localparam logic [CODE_W-1:0] RST_SEL_IN1  = 8'h01;
    localparam logic [CODE_W-1:0] RST_SEL_IN2  = 8'h0b;
    localparam logic [CODE_W-1:0] RST_SEL_REST = 8'h00;
    localparam logic [NUM_VIRT-1:0] RST_VIRT   = 16'h0000;

    // Function codes
    localparam logic [CODE_W-1:0] CODE_NONE      = 8'h00;
    localparam logic [CODE_W-1:0] CODE_SERVO_EN  = 8'h01;
    localparam logic [CODE_W-1:0] CODE_FWD_RUN   = 8'h02;
    localparam logic [CODE_W-1:0] CODE_REV_RUN   = 8'h03;
    localparam logic [CODE_W-1:0] CODE_POS_START = 8'h04;
    localparam logic [CODE_W-1:0] CODE_HOMING    = 8'h05;
    localparam logic [CODE_W-1:0] CODE_HOME_SW   = 8'h06;
    localparam logic [CODE_W-1:0] CODE_POS_LIMIT = 8'h07;
    localparam logic [CODE_W-1:0] CODE_NEG_LIMIT = 8'h08;
    localparam logic [CODE_W-1:0] CODE_FSTOP     = 8'h0a;
    localparam logic [CODE_W-1:0] CODE_ALM_RST   = 8'h0b;
    localparam logic [CODE_W-1:0] CODE_OVERHEAT  = 8'h22;
    localparam logic [CODE_W-1:0] CODE_OVR_EN    = 8'h2b;
    localparam logic [CODE_W-1:0] CODE_OVR_W1    = 8'h2c;
    localparam logic [CODE_W-1:0] CODE_INT_EN    = 8'h30;
    localparam logic [CODE_W-1:0] CODE_SPD_B0    = 8'h33;
    localparam logic [CODE_W-1:0] CODE_POS_A0    = 8'h3c;

    typedef logic [NUM_IN-1:0][CODE_W-1:0] ifr_map_type;

    // Routed internal functions, one bit per function code
    typedef struct packed {
        logic [3:0] override_weight;
        logic [3:0] position_address;
        logic [2:0] speed_select;
        logic       override_enable;
        logic       interrupt_enable;
        logic       regen_overheat;
        logic       alarm_reset;
        logic       forced_stop;
        logic       negative_limit;
        logic       positive_limit;
        logic       home_switch;
        logic       homing_request;
        logic       positioning_start;
        logic       reverse_run;
        logic       forward_run;
        logic       servo_enable;
    } ifr_func_type;

    typedef enum logic {ST_LOAD, ST_RUN} ifr_state_type;

    // Reset code of a select entry
    function automatic logic [CODE_W-1:0] default_code(input int idx);
        if (idx == 0) begin
            return RST_SEL_IN1;
        end else if (idx == 1) begin
            return RST_SEL_IN2;
        end
        return RST_SEL_REST;
    endfunction

endpackage

// >>> design/ifr_sel_mem.sv
// Function select store: one write port, two registered read ports
module ifr_sel_mem
    import ifr_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   wr_en,
    input  wire logic [IDX_W-1:0]       wr_idx,
    input  wire logic [CODE_W-1:0]      wr_code,
    input  wire logic [IDX_W-1:0]       rd_a_idx,
    output      logic [CODE_W-1:0]      rd_a_code,
    input  wire logic [IDX_W-1:0]       rd_b_idx,
    output      logic [CODE_W-1:0]      rd_b_code
);
    logic [CODE_W-1:0] mem_q [NUM_IN];

    // Store, reset to the power-up defaults
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_IN; i++) begin
                mem_q[i] <= default_code(i);
            end
        end else if (wr_en && (32'(wr_idx) < NUM_IN)) begin
            mem_q[wr_idx] <= wr_code;
        end
    end

    // Registered reads; out of range reads as no function
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_a_code <= CODE_NONE;
            rd_b_code <= CODE_NONE;
        end else begin
            rd_a_code <= (32'(rd_a_idx) < NUM_IN) ? mem_q[rd_a_idx] : CODE_NONE;
            rd_b_code <= (32'(rd_b_idx) < NUM_IN) ? mem_q[rd_b_idx] : CODE_NONE;
        end
    end

endmodule // ifr_sel_mem

// >>> design/ifr_top.sv
// Input function router: select store, power-up latch and function routing
//
// Added by the designer: the address map and strobed register access.
module ifr_top
(
    input  wire logic                          clk,
    input  wire logic                          rstn,
    input  wire logic [ifr_pkg::ADDR_W-1:0]    addr,
    input  wire logic [ifr_pkg::DATA_W-1:0]    wdata,
    input  wire logic                          wr_en,
    input  wire logic                          rd_en,
    output      logic [ifr_pkg::DATA_W-1:0]    rdata,
    input  wire logic [ifr_pkg::NUM_HW-1:0]    external_input,
    output      ifr_pkg::ifr_func_type         func_out,
    output      logic                          map_loading
);
    import ifr_pkg::*;

    logic                  rst_meta_q;
    logic                  rst_n_q;
    logic [NUM_VIRT-1:0]   virt_q;
    ifr_state_type         state_q;
    ifr_state_type         state_d;
    logic [IDX_W-1:0]      load_idx_q;
    logic [IDX_W-1:0]      load_idx_d;
    logic [IDX_W-1:0]      load_dst_q;
    logic                  load_pend_q;
    ifr_map_type           active_q;
    ifr_func_type          func_d;
    logic [DATA_W-1:0]     rd_other_q;
    logic [DATA_W-1:0]     rd_other_d;
    logic                  rd_mem_sel_q;
    logic [CODE_W-1:0]     mem_rd_a;
    logic [CODE_W-1:0]     mem_rd_b;

    // Is the address one of the select entries
    function automatic logic is_sel(input logic [ADDR_W-1:0] a);
        return (a <= ADDR_SEL_HW_LAST) ||
               ((a >= ADDR_SEL_VIRT_FIRST) && (a <= ADDR_SEL_VIRT_LAST));
    endfunction

    // Store index of a select address; virtual entries close the gap
    function automatic logic [IDX_W-1:0] sel_index(input logic [ADDR_W-1:0] a);
        if (a >= ADDR_SEL_VIRT_FIRST) begin
            return IDX_W'(a - VIRT_IDX_GAP);
        end
        return IDX_W'(a - ADDR_SEL_HW_FIRST);
    endfunction

    // Contact type differs by source for these four codes
    function automatic logic is_nc_code(input logic [CODE_W-1:0] c);
        return (c == CODE_POS_LIMIT) || (c == CODE_NEG_LIMIT) ||
               (c == CODE_FSTOP) || (c == CODE_OVERHEAT);
    endfunction

    // Level of one routed function: OR of every input selecting it (hardware inputs only for interrupt enable),
    // or the idle level when no such input selects it
    function automatic logic route(input ifr_map_type m,
                                   input logic [NUM_IN-1:0] lvl,
                                   input logic [CODE_W-1:0] c,
                                   input logic idle);
        logic hit;
        logic on;
        logic bit_lvl;
        hit = 1'b0;
        on  = 1'b0;
        for (int i = 0; i < NUM_IN; i++) begin
            bit_lvl = lvl[i];
            if ((i < NUM_HW) && is_nc_code(c)) begin
                bit_lvl = ~lvl[i];
            end
            if ((m[i] == c) && !((i >= NUM_HW) && (c == CODE_INT_EN))) begin
                hit = 1'b1;
                on  = on | bit_lvl;
            end
        end
        return hit ? on : idle;
    endfunction

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // Bus decode
    wire               sel_hit     = is_sel(addr);
    wire [IDX_W-1:0]   sel_idx     = sel_index(addr);
    wire               sel_wr      = wr_en && sel_hit;
    wire               virt_lo_wr  = wr_en && (addr == ADDR_VIRT_LO);
    wire               virt_hi_wr  = wr_en && (addr == ADDR_VIRT_HI);
    wire               restart_wr  = wr_en && (addr == ADDR_RESTART);

    // Editable selections land in the store, never in the live map
    ifr_sel_mem u_sel_mem (
        .clk       (clk),
        .rst_n     (rst_n_q),
        .wr_en     (sel_wr),
        .wr_idx    (sel_idx),
        .wr_code   (wdata),
        .rd_a_idx  (sel_idx),
        .rd_a_code (mem_rd_a),
        .rd_b_idx  (load_idx_q),
        .rd_b_code (mem_rd_b)
    );

    // Virtual input levels written by the host, a byte at a time
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            virt_q <= RST_VIRT;
        end else begin
            if (virt_lo_wr) begin
                virt_q[7:0] <= wdata;
            end
            if (virt_hi_wr) begin
                virt_q[15:8] <= wdata;
            end
        end
    end

    // Load sequencer: one pass over the store after power-up or restart
    always_comb begin
        state_d    = state_q;
        load_idx_d = load_idx_q;
        unique case (state_q)
            ST_LOAD: begin
                if (load_idx_q == LAST_IDX) begin
                    state_d = ST_RUN;
                end else begin
                    load_idx_d = load_idx_q + 5'h01;
                end
            end
            ST_RUN: begin
                load_idx_d = '0;
            end
        endcase
        // A restart models the power cycle that makes edits live
        if (restart_wr) begin
            state_d    = ST_LOAD;
            load_idx_d = '0;
        end
    end

    // Sequencer state; store read data arrive one cycle after the index
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q     <= ST_LOAD;
            load_idx_q  <= '0;
            load_dst_q  <= '0;
            load_pend_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            load_idx_q  <= load_idx_d;
            load_dst_q  <= load_idx_q;
            load_pend_q <= (state_q == ST_LOAD);
        end
    end

    // Live map: changes only during a load pass
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            for (int i = 0; i < NUM_IN; i++) begin
                active_q[i] <= default_code(i);
            end
        end else if (load_pend_q) begin
            active_q[load_dst_q] <= mem_rd_b;
        end
    end

    // Routing; codes without a decode here reach nothing
    wire [NUM_IN-1:0] in_lvl = {virt_q, external_input};

    always_comb begin
        func_d = '0;
        // Basic drive controls
        func_d.servo_enable      = route(active_q, in_lvl, CODE_SERVO_EN, 1'b1);
        func_d.forward_run       = route(active_q, in_lvl, CODE_FWD_RUN, 1'b0);
        func_d.reverse_run       = route(active_q, in_lvl, CODE_REV_RUN, 1'b0);
        func_d.positioning_start = route(active_q, in_lvl, CODE_POS_START, 1'b0);
        func_d.homing_request    = route(active_q, in_lvl, CODE_HOMING, 1'b0);
        func_d.home_switch       = route(active_q, in_lvl, CODE_HOME_SW, 1'b0);
        func_d.positive_limit    = route(active_q, in_lvl, CODE_POS_LIMIT, 1'b0);
        func_d.negative_limit    = route(active_q, in_lvl, CODE_NEG_LIMIT, 1'b0);
        func_d.forced_stop       = route(active_q, in_lvl, CODE_FSTOP, 1'b1);
        func_d.alarm_reset       = route(active_q, in_lvl, CODE_ALM_RST, 1'b0);
        func_d.regen_overheat    = route(active_q, in_lvl, CODE_OVERHEAT, 1'b0);
        func_d.interrupt_enable  = route(active_q, in_lvl, CODE_INT_EN, 1'b0);
        func_d.override_enable   = route(active_q, in_lvl, CODE_OVR_EN, 1'b0);
        // Selector bits use consecutive codes
        for (int b = 0; b < 3; b++) begin
            func_d.speed_select[b] =
                route(active_q, in_lvl, CODE_W'(CODE_SPD_B0 + b), 1'b0);
        end
        for (int b = 0; b < 4; b++) begin
            func_d.position_address[b] =
                route(active_q, in_lvl, CODE_W'(CODE_POS_A0 + b), 1'b0);
            func_d.override_weight[b] =
                route(active_q, in_lvl, CODE_W'(CODE_OVR_W1 + b), 1'b0);
        end
    end

    // Outputs straight from flops; one cycle of latency on every path
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            func_out    <= '0;
            map_loading <= 1'b1;
        end else begin
            func_out    <= func_d;
            map_loading <= (state_d == ST_LOAD);
        end
    end

    // Read mux for everything outside the store; unmapped reads zero
    always_comb begin
        rd_other_d = '0;
        unique case (addr)
            ADDR_VIRT_LO:   rd_other_d = virt_q[7:0];
            ADDR_VIRT_HI:   rd_other_d = virt_q[15:8];
            ADDR_RESTART:   rd_other_d = {7'h00, map_loading};
            ADDR_PIN_LEVEL: rd_other_d = {2'h0, external_input};
            ADDR_FUNC0:     rd_other_d = func_out[7:0];
            ADDR_FUNC1:     rd_other_d = func_out[15:8];
            ADDR_FUNC2:     rd_other_d = func_out[23:16];
            default:        rd_other_d = '0;
        endcase
    end

    // Read capture; the store supplies its own registered word
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rd_other_q   <= '0;
            rd_mem_sel_q <= 1'b0;
        end else begin
            rd_other_q   <= rd_en ? rd_other_d : '0;
            rd_mem_sel_q <= rd_en && sel_hit;
        end
    end

    // Picks between two flops only, so the path stays short
    assign rdata = rd_mem_sel_q ? mem_rd_a : rd_other_q;

endmodule // ifr_top

// >>> tb/ifr_switch_model.sv
// Contact bank standing in for the six field switches
module ifr_switch_model (
    input  wire logic                       clk,
    input  wire logic [ifr_pkg::NUM_HW-1:0] closed,
    output      logic [ifr_pkg::NUM_HW-1:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    import ifr_pkg::*;
    // Contacts settle on the clock; 1 means closed, as wired to the router
    always_ff @(posedge clk) begin
        pins <= closed;
    end
endmodule // ifr_switch_model

// >>> tb/ifr_props.sv
// Port checker for the input function router
module ifr_props (
    input wire logic                       clk,
    input wire logic                       rstn,
    input wire logic [ifr_pkg::ADDR_W-1:0] addr,
    input wire logic [ifr_pkg::DATA_W-1:0] wdata,
    input wire logic                       wr_en,
    input wire logic                       rd_en,
    input wire logic [ifr_pkg::DATA_W-1:0] rdata,
    input wire logic [ifr_pkg::NUM_HW-1:0] external_input,
    input wire ifr_pkg::ifr_func_type      func_out,
    input wire logic                       map_loading
);
    timeunit 1ns;
    timeprecision 1ps;
    import ifr_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic fresh_q;
    wire  restart = wr_en && addr == ADDR_RESTART;
    wire  calm    = fresh_q && !map_loading && !wr_en;
    // Live map still holds reset defaults until the first restart
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fresh_q <= 1'b1;
        end else if (restart) begin
            fresh_q <= 1'b0;
        end
    end
    a_restart_loads: assert property (restart |=> map_loading)
        else $error("restart did not start a load");
    a_load_ends: assert property ($rose(map_loading) |-> ##[1:30] !map_loading)
        else $error("map load never finished");
    a_func_holds: assert property (!map_loading ##1 (!wr_en && !map_loading)
        ##1 (!map_loading && $stable(external_input)) |=> $stable(func_out))
        else $error("functions moved with no cause");
    a_default_servo: assert property (calm |=>
        func_out.servo_enable == $past(external_input[0]))
        else $error("input one not routed to servo enable");
    a_default_alarm: assert property (calm |=>
        func_out.alarm_reset == $past(external_input[1]))
        else $error("input two not routed to alarm reset");
    a_absent_on: assert property (calm |-> func_out.forced_stop)
        else $error("unassigned forced stop not asserted");
    a_absent_off: assert property (calm |-> !(func_out.forward_run
        || func_out.positive_limit || func_out.positioning_start) && func_out.speed_select == 3'h0)
        else $error("unassigned function asserted");
    a_gap_reads_zero: assert property (rd_en && addr inside {5'h06, 5'h07, 5'h1f}
        |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_func_readback: assert property (rd_en && addr == ADDR_FUNC0
        |=> rdata == $past(func_out[7:0]))
        else $error("function byte read back wrong");
endmodule // ifr_props

bind ifr_top ifr_props u_props (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .external_input(external_input),
    .func_out(func_out), .map_loading(map_loading));

// >>> tb/ifr_top_bench.sv
// Self-checking bench for the input function router
module ifr_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ifr_pkg::*;
    logic              clk = 1'b0;
    logic              rstn = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic              wr_en = 1'b0;
    logic              rd_en = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [NUM_HW-1:0] closed = '0;
    logic [NUM_HW-1:0] pins;
    ifr_func_type      func;
    logic              loading;
    int                fail_count = 0;
    int                checks = 0;
    int                codes[26] = '{1, 2, 3, 4, 5, 6, 7, 8, 10, 11, 34, 43, 44, 45, 46,
                                     47, 48, 51, 52, 53, 60, 61, 62, 63, 14, 0};
    // Free-running system clock
    always #5 clk = ~clk;
    ifr_top dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .external_input(pins), .func_out(func),
        .map_loading(loading));
    ifr_switch_model u_sw (.clk(clk), .closed(closed), .pins(pins));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string what);
        checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        // Taken at the close of the cycle in which the data stand
        @(posedge clk);
        d = rdata;
    endtask
    task automatic wait_load();
        int n;
        n = 0;
        // Let the restart edge pass first; its flag update lands after this call
        do begin
            @(posedge clk);
            n++;
        end while (loading !== 1'b0 && n < 100);
        if (loading !== 1'b0) begin
            check(1'b0, "map load hung");
            end_of_test();
        end
    endtask
    // Which function bit a code should move; empty for codes that drive nothing
    function automatic ifr_func_type fmask(input int c);
        ifr_func_type f;
        f = '0;
        case (c)
            1: f.servo_enable = 1'b1;
            2: f.forward_run = 1'b1;
            3: f.reverse_run = 1'b1;
            4: f.positioning_start = 1'b1;
            5: f.homing_request = 1'b1;
            6: f.home_switch = 1'b1;
            7: f.positive_limit = 1'b1;
            8: f.negative_limit = 1'b1;
            10: f.forced_stop = 1'b1;
            11: f.alarm_reset = 1'b1;
            34: f.regen_overheat = 1'b1;
            43: f.override_enable = 1'b1;
            44, 45, 46, 47: f.override_weight[c-44] = 1'b1;
            48: f.interrupt_enable = 1'b1;
            51, 52, 53: f.speed_select[c-51] = 1'b1;
            60, 61, 62, 63: f.position_address[c-60] = 1'b1;
            default: ;
        endcase
        return f;
    endfunction
    // Route one code from a random input, then swing that input both ways
    task automatic try(input int c, input bit virt);
        int                idx;
        logic [ADDR_W-1:0] sel;
        logic [15:0]       vlev;
        ifr_func_type      m;
        ifr_func_type      s0;
        logic              want;
        logic [DATA_W-1:0] rb;
        idx = virt ? $urandom_range(15) : 2 + $urandom_range(3);
        sel = virt ? ADDR_SEL_VIRT_FIRST + 5'(idx) : 5'(idx);
        closed <= '0;
        for (int a = 2; a < 24; a++) begin
            wr(5'(a), 8'h00);
        end
        wr(sel, 8'(c));
        wr(ADDR_RESTART, 8'h00);
        wait_load();
        wr(sel, 8'h00);
        m = fmask(c);
        for (int l = 0; l < 2; l++) begin
            if (virt) begin
                vlev = 16'(l) << idx;
                wr(ADDR_VIRT_LO, vlev[7:0]);
                wr(ADDR_VIRT_HI, vlev[15:8]);
            end else begin
                closed <= 6'(l) << idx;
            end
            repeat (3) @(posedge clk);
            want = (virt && c == 48) ? 1'b0 : (!virt && c inside {7, 8, 10, 34}) ? l == 0 : l == 1;
            if (l == 0) begin
                s0 = func;
            end
            if (m != '0) begin
                check((|(func & m)) === want, "routed level wrong");
            end else if (l == 1) begin
                check(func === s0, "unconnected input moved a function");
            end
            // Top byte holds only selector bits, all unassigned but the one under test
            rd(ADDR_FUNC2, rb);
            check(rb === (want ? m[23:16] : 8'h00), "function byte two readback");
        end
    endtask
    // Main sequence
    initial begin
        logic [DATA_W-1:0] d;
        logic [DATA_W-1:0] c;
        int                seed_v;
        seed_v = $urandom(32'h7beeaa41);
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        for (int a = 0; a < 24; a++) begin
            rd(5'(a), d);
            check(d === (a == 0 ? 8'h01 : a == 1 ? 8'h0b : 8'h00), "select reset value");
        end
        rd(5'h1f, d);
        check(d === 8'h00, "unmapped read");
        wait_load();
        repeat (20) begin
            closed <= 6'($urandom);
            repeat (3) @(posedge clk);
            check(func.servo_enable === closed[0], "input one routing");
            check(func.alarm_reset === closed[1], "input two routing");
            check(func.forced_stop === 1'b1, "absent forced stop");
            check(func.forward_run === 1'b0, "absent direction");
            rd(ADDR_FUNC0, d);
            check(d === {7'h00, closed[0]}, "function byte readback");
        end
        c = 8'($urandom);
        wr(ADDR_SEL_HW_FIRST + 5'h02, c);
        wr(ADDR_SEL_VIRT_LAST, ~c);
        rd(ADDR_SEL_HW_FIRST + 5'h02, d);
        check(d === c, "hardware select readback");
        rd(ADDR_SEL_VIRT_LAST, d);
        check(d === ~c, "virtual select readback");
        foreach (codes[i]) begin
            try(codes[i], 1'b0);
            try(codes[i], 1'b1);
        end
        end_of_test();
    end
endmodule // ifr_top_bench
